// file: mdio_master_model.sv
// Station management controller model that drives MDC and MDIO frames at the register bank.
// Assumes an external pull-up on MDIO and a shared wire resolved by the testbench.
`timescale 1ns/1ps
`include "phy_regs_consts.svh"

module mdio_master_model (
    input wire logic i_clk,
    output logic o_mdc,
    output logic o_mdio,
    output logic o_oe,
    input wire logic i_mdio
);
    import phy_regs_pkg::*;

    // Idle state: clock parked low, wire released to the pull-up.
    initial begin
        o_mdc = 1'b0;
        o_mdio = 1'b1;
        o_oe = 1'b0;
    end

    // One MDC period of 16 system clocks, so the slave's synchronisers see every level.
    task automatic step(input logic b, input logic drv, output logic s);
        @(posedge i_clk);
        #1;
        o_mdc = 1'b0;
        o_mdio = b;
        o_oe = drv;
        repeat (8) @(posedge i_clk);
        #1;
        o_mdc = 1'b1;
        s = i_mdio;
        repeat (7) @(posedge i_clk);
    endtask : step

    // Full frame: preamble, start, opcode, addresses, turnaround and sixteen data bits.
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input reg_word_t wd, output reg_word_t rd);
        logic [13:0] hdr;
        logic s;
        logic wr;
        rd = 16'h0000;
        wr = (op == `OP_WRITE);
        // Writes to reserved addresses are never issued.
        if (wr && (ra inside {[5'h08 : 5'h0F], [5'h16 : 5'h17], [5'h19 : 5'h1F]})) return;
        hdr = {2'b01, op, pa, ra};
        step(1'b1, 1'b1, s);
        step(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) step(hdr[i], 1'b1, s);
        step(1'b1, wr, s);
        step(1'b0, wr, s);
        for (int i = 15; i >= 0; i--) begin
            step(wd[i], wr, s);
            rd[i] = s;
        end
        step(1'b1, 1'b0, s);
        // Return off the clock edge so that the caller's next change cannot race the slave.
        #1;
    endtask : frame
endmodule : mdio_master_model

// file: phy_autoneg_irq_diag_regs.sv
// Per-port negotiation, interrupt, diagnostic and test registers behind a serial management slave.
// Assumes status inputs come from logic on I_CLK; MDC, MDIO and straps come from pins.
`timescale 1ns/1ps
`include "phy_regs_consts.svh"

// Function
// [R1] Base-page partner word is stored whole and read back read-only.
// [R2] Next-page partner word uses the same storage, read-only, its own layout.
// [R3] Parallel-detect fault latches high and clears only on expansion register read.
// [R4] Page-received flag sets on each stored partner word, clears on expansion read.
// [R5] Expansion bit 0 reports partner negotiation ability, read-only, reset zero.
// [R6] Local next-page ability bit of expansion register is hardwired to one.
// [R7] Local next-page word fields writable except bit 14; message page resets to one.
// [R8] Toggle bit becomes inverse of previously transmitted toggle value.
// [R9] Controller never writes reserved addresses and ignores their read values.
// [R10] Misc bit 14 selects interrupt pin active level, reset zero.
// [R11] Misc bit 13 read-only shows forced jam transmission, reset zero.
// [R12] Interrupt enables at bits 15 to 8, writable, reset zero.
// [R13] Status bits set by events, cleared by read; bit 7 for jabber.
// [R14] Status bit 6 sets on rising edge of receive error.
// [R15] Status bit 5 on new page, bit 4 on parallel detect fault.
// [R16] Status bit 3 on partner burst carrying acknowledge.
// [R17] Status bit 2 on link going from OK to not OK only.
// [R18] Status bit 1 on remote fault, bit 0 on negotiation complete.
// [R19] Diagnostic bits 11 and 10 show negotiated duplex and speed, reset zero.
// [R20] Diagnostic bit 9 shows receive pass indication from the receiver.
// [R21] Diagnostic bit 8 latches receiver lock until the register is read.
// [R22] Test bit 6 selects transformer ratio, default taken from a strap pin.
// [R23] Interrupt pin active when any enabled status bit is set.
module phy_autoneg_irq_diag_regs (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_CE,
    input wire logic I_MDC,
    input wire logic I_MDIO_I,
    output logic O_MDIO_O,
    output logic O_MDIO_OE_N,
    input wire logic [4:0] I_PHY_ADDR_STRAP,
    input wire logic I_TRANSFORMER_RATIO_STRAP,
    input wire phy_regs_pkg::reg_word_t I_PARTNER_WORD,
    input wire logic I_PARTNER_WORD_STB,
    input wire logic I_PARTNER_AN_ABLE,
    input wire logic I_PARTNER_NP_ABLE,
    input wire logic I_PD_FAULT,
    input wire logic I_JABBER,
    input wire logic I_RX_ERR,
    input wire logic I_PARTNER_ACK,
    input wire logic I_LINK_OK,
    input wire logic I_REMOTE_FAULT,
    input wire logic I_AN_DONE,
    input wire logic I_NP_SENT_STB,
    input wire logic I_NP_SENT_TOGGLE,
    input wire logic I_FORCE_JAM,
    input wire logic I_NEG_DUPLEX,
    input wire logic I_NEG_SPEED,
    input wire logic I_RX_PASS,
    input wire logic I_RX_LOCK,
    output phy_regs_pkg::reg_word_t O_NEXT_PAGE_WORD,
    output logic O_TRANSFORMER_RATIO,
    output logic O_COMPLIANCE_NORMAL,
    output logic O_INT
);
    import phy_regs_pkg::*;

    // Pin synchronisers; the first stage of each is read only by the second.
    logic mdc_s1_r, mdc_s2_r, mdc_s3_r;
    logic mdio_s1_r, mdio_s2_r;
    logic ratio_s1_r, ratio_s2_r;
    logic [4:0] addr_s1_r, addr_s2_r, phy_addr_r;

    // Frame engine state.
    mdio_state_t state_r;
    logic [3:0] cnt_r;
    logic [11:0] hdr_r;
    logic is_read_r, bit_prev_r;
    logic [4:0] reg_addr_r;
    reg_word_t shift_r;
    logic mdio_o_r, mdio_oe_n_r;

    // Register storage.
    reg_word_t partner_r, np_r, misc_r, test_r;
    logic [7:0] irq_en_r, irq_stat_r;
    logic pd_fault_r, page_rx_r, an_able_r, lp_np_able_r;
    logic jam_r, duplex_r, speed_r, rx_pass_r, lock_r;
    logic rx_err_q_r, link_ok_q_r, int_r;

    always_ff @(posedge I_CLK) begin
        if (I_CE) begin
            mdc_s1_r <= I_MDC;
            mdc_s2_r <= mdc_s1_r;
            mdc_s3_r <= mdc_s2_r;
            mdio_s1_r <= I_MDIO_I;
            mdio_s2_r <= mdio_s1_r;
            ratio_s1_r <= I_TRANSFORMER_RATIO_STRAP;
            ratio_s2_r <= ratio_s1_r;
            addr_s1_r <= I_PHY_ADDR_STRAP;
            addr_s2_r <= addr_s1_r;
        end
    end

    // Frame decode; a read only answers when the address matches this port.
    wire mdc_rise = I_CE & mdc_s2_r & ~mdc_s3_r;
    wire [12:0] hdr_full = {hdr_r, mdio_s2_r};
    wire hdr_op_read = hdr_full[11:10] == `OP_READ;
    wire hdr_op_write = hdr_full[11:10] == `OP_WRITE;
    wire hdr_ok = hdr_full[12] & (hdr_op_read | hdr_op_write) & (hdr_full[9:5] == phy_addr_r);
    wire rd_take = mdc_rise & (state_r == ST_TA) & is_read_r & (cnt_r == 4'h0);
    wire wr_take = mdc_rise & (state_r == ST_DATA) & ~is_read_r & (cnt_r == `DATA_LAST_BIT);
    wire [15:0] wr_data = {shift_r[14:0], mdio_s2_r};

    // Unmapped addresses read zero and ignore writes; the controller never writes the reserved ones. [R9]
    wire rd_clr_exp = rd_take & (reg_addr_r == `ADDR_EXPANSION);
    wire rd_clr_irq = rd_take & (reg_addr_r == `ADDR_IRQ);
    wire rd_clr_diag = rd_take & (reg_addr_r == `ADDR_DIAGNOSTIC);
    wire wr_np = wr_take & (reg_addr_r == `ADDR_LOCAL_NEXT_PAGE);
    wire wr_misc = wr_take & (reg_addr_r == `ADDR_MISC_FEATURES);
    wire wr_irq = wr_take & (reg_addr_r == `ADDR_IRQ);
    wire wr_test = wr_take & (reg_addr_r == `ADDR_TEST);

    // Register views as the controller reads them.
    wire [15:0] exp_word = {11'h000, pd_fault_r, lp_np_able_r, 1'b1, page_rx_r, an_able_r}; // R6 R5
    wire [15:0] misc_word = {misc_r[15:14], jam_r, misc_r[12:0]}; // R11
    wire [15:0] irq_word = {irq_en_r, irq_stat_r};
    wire [15:0] diag_word = {4'h0, duplex_r, speed_r, rx_pass_r, lock_r, `DIAG_RESERVED_LOW}; // R19
    logic [15:0] rd_word;
    always_comb begin
        case (reg_addr_r)
            `ADDR_PARTNER_ABILITY: rd_word = partner_r; // R1 R2
            `ADDR_EXPANSION: rd_word = exp_word;
            `ADDR_LOCAL_NEXT_PAGE: rd_word = np_r;
            `ADDR_MISC_FEATURES: rd_word = misc_word;
            `ADDR_IRQ: rd_word = irq_word;
            `ADDR_DIAGNOSTIC: rd_word = diag_word;
            `ADDR_TEST: rd_word = test_r;
            default: rd_word = 16'h0000;
        endcase
    end

    // Management frame engine; answers change just after the MDC rising edge it sampled.
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            hdr_r <= 12'h000;
            is_read_r <= 1'b0;
            bit_prev_r <= 1'b0;
            reg_addr_r <= 5'h00;
            shift_r <= 16'h0000;
            mdio_o_r <= 1'b1;
            mdio_oe_n_r <= 1'b1;
        end else if (mdc_rise) begin
            case (state_r)
                ST_IDLE: begin
                    bit_prev_r <= mdio_s2_r;
                    cnt_r <= 4'h0;
                    if (bit_prev_r && !mdio_s2_r) begin
                        state_r <= ST_HDR;
                    end
                end
                ST_HDR: begin
                    hdr_r <= hdr_full[11:0];
                    cnt_r <= cnt_r + 4'h1;
                    // A refused frame still runs its length aimed at an unmapped address,
                    // so that its own data bits can never be taken for a new start.
                    if (cnt_r == `HDR_LAST_BIT) begin
                        cnt_r <= 4'h0;
                        is_read_r <= hdr_ok & hdr_op_read;
                        reg_addr_r <= hdr_ok ? hdr_full[4:0] : 5'h00;
                        bit_prev_r <= 1'b0;
                        state_r <= ST_TA;
                    end
                end
                ST_TA: begin
                    cnt_r <= 4'h1;
                    if (cnt_r == 4'h0) begin
                        if (is_read_r) begin
                            mdio_oe_n_r <= 1'b0;
                            mdio_o_r <= 1'b0;
                            shift_r <= rd_word;
                        end
                    end else begin
                        cnt_r <= 4'h0;
                        state_r <= ST_DATA;
                        if (is_read_r) begin
                            mdio_o_r <= shift_r[15];
                            shift_r <= {shift_r[14:0], 1'b0};
                        end
                    end
                end
                ST_DATA: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (is_read_r) begin
                        mdio_o_r <= shift_r[15];
                        shift_r <= {shift_r[14:0], 1'b0};
                    end else begin
                        shift_r <= wr_data;
                    end
                    if (cnt_r == `DATA_LAST_BIT) begin
                        mdio_oe_n_r <= 1'b1;
                        mdio_o_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Events; edge detectors keep a held level from setting its flag again after a read.
    wire rx_err_rise = I_RX_ERR & ~rx_err_q_r; // R14
    wire link_fall = ~I_LINK_OK & link_ok_q_r; // R17
    wire [7:0] irq_event = {I_JABBER, rx_err_rise, I_PARTNER_WORD_STB, I_PD_FAULT, // R13 R15
        I_PARTNER_ACK, link_fall, I_REMOTE_FAULT, I_AN_DONE}; // R16 R18
    wire [7:0] irq_stat_nxt = (irq_stat_r & ~{8{rd_clr_irq}}) | irq_event;
    wire irq_any = |(irq_en_r & irq_stat_nxt);

    // Latched flags: a set in the cycle of the clearing read wins over the clear.
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            irq_stat_r <= 8'h00;
            pd_fault_r <= 1'b0;
            page_rx_r <= 1'b0;
            lock_r <= 1'b0;
            rx_err_q_r <= 1'b0;
            link_ok_q_r <= 1'b0;
            int_r <= 1'b0;
        end else if (I_CE) begin
            irq_stat_r <= irq_stat_nxt; // R13
            pd_fault_r <= I_PD_FAULT | (pd_fault_r & ~rd_clr_exp); // R3
            page_rx_r <= I_PARTNER_WORD_STB | (page_rx_r & ~rd_clr_exp); // R4
            lock_r <= I_RX_LOCK | (lock_r & ~rd_clr_diag); // R21
            rx_err_q_r <= I_RX_ERR;
            link_ok_q_r <= I_LINK_OK;
            int_r <= irq_any ? misc_r[`MISC_POLARITY_BIT] : ~misc_r[`MISC_POLARITY_BIT]; // R23 R10
        end
    end

    // Live status sampled into flops so every field reads zero out of reset.
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            partner_r <= 16'h0000;
            an_able_r <= 1'b0;
            lp_np_able_r <= 1'b0;
            jam_r <= 1'b0;
            duplex_r <= 1'b0;
            speed_r <= 1'b0;
            rx_pass_r <= 1'b0;
        end else if (I_CE) begin
            if (I_PARTNER_WORD_STB) begin
                partner_r <= I_PARTNER_WORD; // R1 R2
            end
            an_able_r <= I_PARTNER_AN_ABLE; // R5
            lp_np_able_r <= I_PARTNER_NP_ABLE;
            jam_r <= I_FORCE_JAM; // R11
            duplex_r <= I_NEG_DUPLEX; // R19
            speed_r <= I_NEG_SPEED;
            rx_pass_r <= I_RX_PASS; // R20
        end
    end

    // Writable registers; straps are caught while the synchronous reset is held.
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            np_r <= `NP_RESET; // R7
            misc_r <= 16'h0000; // R10
            irq_en_r <= 8'h00; // R12
            test_r <= {`TEST_RESET_HIGH, `TEST_RESET_MID, 1'b0, ratio_s2_r, 1'b1, 5'h00}; // R22
            phy_addr_r <= addr_s2_r;
        end else if (I_CE) begin
            if (wr_np) begin
                np_r <= wr_data & `NP_WRITE_MASK; // R7
            end
            if (I_NP_SENT_STB) begin
                np_r[`NP_TOGGLE_BIT] <= ~I_NP_SENT_TOGGLE; // R8
            end
            if (wr_misc) begin
                misc_r <= wr_data & `MISC_WRITE_MASK; // R10
            end
            if (wr_irq) begin
                irq_en_r <= wr_data[15:8]; // R12
            end
            if (wr_test) begin
                test_r <= wr_data & `TEST_WRITE_MASK; // R22
            end
        end
    end

    assign O_MDIO_O = mdio_o_r;
    assign O_MDIO_OE_N = mdio_oe_n_r;
    assign O_NEXT_PAGE_WORD = np_r;
    assign O_TRANSFORMER_RATIO = test_r[`TEST_RATIO_BIT];
    assign O_COMPLIANCE_NORMAL = test_r[5];
    assign O_INT = int_r;

    // Checks on the register behaviour.
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);

    chk_partner_store: assert property ( // R1
        I_CE && I_PARTNER_WORD_STB |=> partner_r == $past(I_PARTNER_WORD))
        else $error("partner word not stored");
    chk_pd_fault_hold: assert property ( // R3
        I_CE && pd_fault_r && !rd_clr_exp |=> pd_fault_r)
        else $error("parallel detect fault dropped without read");
    chk_page_rx_set: assert property ( // R4
        I_CE && I_PARTNER_WORD_STB |=> page_rx_r && irq_stat_r[5])
        else $error("page received flags not set");
    chk_np_able_one: assert property ( // R6
        exp_word[`EXP_NP_ABLE_BIT] && !exp_word[15])
        else $error("next page ability bit wrong");
    chk_toggle_invert: assert property ( // R8
        I_CE && I_NP_SENT_STB |=> np_r[`NP_TOGGLE_BIT] != $past(I_NP_SENT_TOGGLE))
        else $error("toggle not inverted");
    chk_np_reserved_zero: assert property ( // R7
        !np_r[`NP_RESERVED_BIT])
        else $error("next page reserved bit set");
    chk_rx_err_edge: assert property ( // R14
        I_CE && I_RX_ERR && rx_err_q_r && !irq_stat_r[6] && !rd_clr_irq |=> !irq_stat_r[6])
        else $error("receive error flag set by held level");
    chk_link_drop_set: assert property ( // R17
        I_CE && link_fall |=> irq_stat_r[2])
        else $error("link drop flag not set");
    chk_irq_clear_read: assert property ( // R13
        I_CE && rd_clr_irq && !(|irq_event) |=> irq_stat_r == 8'h00)
        else $error("status not cleared by read");
    chk_irq_pin_level: assert property ( // R23
        I_CE ##1 1'b1 |-> O_INT == ($past(irq_any) ? misc_r[14] : !misc_r[14]) || $past(wr_misc))
        else $error("interrupt pin level wrong");
    chk_lock_latch: assert property ( // R21
        I_CE && lock_r && !rd_clr_diag |=> lock_r)
        else $error("lock flag dropped without read");
    chk_drive_window: assert property (
        $fell(mdio_oe_n_r) |-> ##1 !mdio_oe_n_r [*8])
        else $error("read data window cut short");
    chk_jabber_set: assert property ( // R13
        I_CE && I_JABBER |=> irq_stat_r[7])
        else $error("jabber flag not set");
    chk_rx_err_set: assert property ( // R14
        I_CE && rx_err_rise |=> irq_stat_r[6])
        else $error("receive error edge not flagged");

    cov_read_frame: cover property (rd_take ##1 !mdio_oe_n_r);
    cov_write_irq: cover property (wr_irq ##1 irq_en_r != 8'h00);
    cov_irq_raise: cover property (I_CE && irq_any ##1 O_INT == misc_r[14]);
    cov_set_on_clear: cover property (rd_clr_exp && I_PARTNER_WORD_STB);
endmodule : phy_autoneg_irq_diag_regs

// file: phy_regs_consts.svh
// Offsets, field positions, reset values and frame counts of the management register bank.
// Assumes inclusion by bare name from the register bank, the controller model and the bench.
`ifndef PHY_REGS_CONSTS_SVH
`define PHY_REGS_CONSTS_SVH

// Register addresses on the serial management bus.
`define ADDR_PARTNER_ABILITY 5'h05
`define ADDR_EXPANSION 5'h06
`define ADDR_LOCAL_NEXT_PAGE 5'h07
`define ADDR_MISC_FEATURES 5'h10
`define ADDR_IRQ 5'h11
`define ADDR_DIAGNOSTIC 5'h12
`define ADDR_TEST 5'h13

// Field positions.
`define EXP_PD_FAULT_BIT 4
`define EXP_LP_NP_ABLE_BIT 3
`define EXP_NP_ABLE_BIT 2
`define EXP_PAGE_RX_BIT 1
`define EXP_LP_AN_ABLE_BIT 0
`define NP_RESERVED_BIT 14
`define NP_TOGGLE_BIT 11
`define MISC_POLARITY_BIT 14
`define MISC_JAM_BIT 13
`define DIAG_LOCK_BIT 8
`define TEST_RATIO_BIT 6

// Reset values and masks.
`define NP_RESET 16'h2001
`define NP_WRITE_MASK 16'hBFFF
`define MISC_WRITE_MASK 16'hDFF0
`define TEST_RESET_HIGH 4'h8
`define TEST_RESET_MID 4'h2
`define TEST_WRITE_MASK 16'hFFE0
`define DIAG_RESERVED_LOW 8'h22

// Management frame fields and bit counts.
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define HDR_LAST_BIT 4'hC
`define DATA_LAST_BIT 4'hF

`endif

// file: phy_regs_pkg.sv
// Types shared by the management register bank.
// Assumes the constants header is on the include path.
package phy_regs_pkg;
    // Serial management frame states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HDR,
        ST_TA,
        ST_DATA
    } mdio_state_t;
    typedef logic [15:0] reg_word_t;
endpackage : phy_regs_pkg

// file: tb.sv
// Self-checking bench for the negotiation, interrupt, diagnostic and test register bank.
// Assumes the controller model drives all management frames; events come from this bench.
`timescale 1ns/1ps
`include "phy_regs_consts.svh"

module tb;
    import phy_regs_pkg::*;

    logic I_CLK, I_SYS_RST, m_mdc, m_o, m_oe, mdio_o, mdio_oe_n, an_able, np_able, np_stb;
    logic np_tog, jam, negotiated_duplex, spd, pass, lock, ratio, comp, irq, ce;
    logic [7:0] ev;
    reg_word_t pw, npw, d;
    int errors, check_count;
    wire mdio_wire;

    // The wire is the device's drive when enabled, else the controller, else the pull-up.
    assign mdio_wire = !mdio_oe_n ? mdio_o : (m_oe ? m_o : 1'b1);

    phy_autoneg_irq_diag_regs uut (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_CE(ce),
        .I_MDC(m_mdc), .I_MDIO_I(mdio_wire), .O_MDIO_O(mdio_o), .O_MDIO_OE_N(mdio_oe_n),
        .I_PHY_ADDR_STRAP(5'h03), .I_TRANSFORMER_RATIO_STRAP(1'b1), .I_PARTNER_WORD(pw),
        .I_PARTNER_WORD_STB(ev[5]), .I_PARTNER_AN_ABLE(an_able), .I_PARTNER_NP_ABLE(np_able),
        .I_PD_FAULT(ev[4]), .I_JABBER(ev[7]), .I_RX_ERR(ev[6]), .I_PARTNER_ACK(ev[3]),
        .I_LINK_OK(~ev[2]), .I_REMOTE_FAULT(ev[1]), .I_AN_DONE(ev[0]), .I_NP_SENT_STB(np_stb),
        .I_NP_SENT_TOGGLE(np_tog), .I_FORCE_JAM(jam), .I_NEG_DUPLEX(negotiated_duplex), .I_NEG_SPEED(spd),
        .I_RX_PASS(pass), .I_RX_LOCK(lock), .O_NEXT_PAGE_WORD(npw),
        .O_TRANSFORMER_RATIO(ratio), .O_COMPLIANCE_NORMAL(comp), .O_INT(irq));

    mdio_master_model mst (.i_clk(I_CLK), .o_mdc(m_mdc), .o_mdio(m_o), .o_oe(m_oe),
        .i_mdio(mdio_wire));

    // Free-running 250 MHz system clock.
    initial begin
        I_CLK = 1'b0;
        forever #2 I_CLK = ~I_CLK;
    end

    // Counts every comparison and reports the ones that differ.
    task automatic check(input string name, input reg_word_t seen, input reg_word_t exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic rd(input logic [4:0] a, output reg_word_t v);
        mst.frame(`OP_READ, 5'h03, a, 16'h0000, v);
    endtask : rd

    task automatic wr(input logic [4:0] a, input reg_word_t v);
        reg_word_t dummy;
        mst.frame(`OP_WRITE, 5'h03, a, v, dummy);
    endtask : wr

    // Reads a register and compares it in one call.
    task automatic rdc(input logic [4:0] a, input reg_word_t exp);
        reg_word_t v;
        rd(a, v);
        check($sformatf("reg_%h", a), v, exp);
    endtask : rdc

    // Pulses one event line; receive error and link loss are levels left asserted.
    task automatic pulse(input int b);
        @(posedge I_CLK);
        #1;
        ev[b] = 1'b1;
        @(posedge I_CLK);
        #1;
        if (b != 6 && b != 2) ev[b] = 1'b0;
        @(posedge I_CLK);
        #1;
    endtask : pulse

    // Single verdict point for the normal end and for the watchdog.
    task automatic results();
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // Watchdog sized well above the roughly sixty frames of the sequence.
    initial begin
        repeat (80000) @(posedge I_CLK);
        errors++;
        results();
    end

    initial begin
        errors = 0;
        check_count = 0;
        I_SYS_RST = 1'b1;
        {an_able, np_able, np_stb, np_tog, jam, negotiated_duplex, spd, pass, lock} = 9'h000;
        ev = 8'h00;
        ce = 1'b1;
        pw = 16'h0000;
        repeat (20) @(posedge I_CLK);
        #1;
        I_SYS_RST = 1'b0;
        repeat (4) @(posedge I_CLK);
        #1;
        // Reset values, outputs and an unmapped address.
        check("np_port", npw, 16'h2001);
        check("ratio", {15'h0000, ratio}, 16'h0001);
        check("comp", {15'h0000, comp}, 16'h0001);
        check("int_idle", {15'h0000, irq}, 16'h0001);
        rdc(5'h05, 16'h0000);
        rdc(5'h06, 16'h0004);
        rdc(5'h07, 16'h2001);
        rdc(5'h10, 16'h0000);
        rdc(5'h11, 16'h0000);
        rdc(5'h12, 16'h0022);
        rdc(5'h13, 16'h8260);
        rdc(5'h09, 16'h0000);
        // Partner words in both layouts and the page-received flag.
        pw = 16'hA5C3;
        pulse(5);
        rdc(5'h05, 16'hA5C3);
        rdc(5'h06, 16'h0006);
        rdc(5'h06, 16'h0004);
        pw = 16'h3ABC;
        pulse(5);
        rdc(5'h05, 16'h3ABC);
        an_able = 1'b1;
        np_able = 1'b1;
        pulse(4);
        rdc(5'h06, 16'h001F);
        rdc(5'h06, 16'h000D);
        // Local next page word: writable fields, reserved bit, toggle and refused frame.
        wr(5'h07, 16'hFFFF);
        rdc(5'h07, 16'hBFFF);
        check("np_port_w", npw, 16'hBFFF);
        wr(5'h07, 16'h0000);
        @(posedge I_CLK);
        #1;
        np_stb = 1'b1;
        @(posedge I_CLK);
        #1;
        np_stb = 1'b0;
        rdc(5'h07, 16'h0800);
        np_tog = 1'b1;
        np_stb = 1'b1;
        @(posedge I_CLK);
        #1;
        np_stb = 1'b0;
        mst.frame(`OP_WRITE, 5'h04, 5'h07, 16'h1234, d);
        rdc(5'h07, 16'h0000);
        // Every status source alone, then cleared by the read.
        for (int b = 7; b >= 0; b--) begin
            rd(5'h11, d);
            pulse(b);
            rdc(5'h11, reg_word_t'(16'h0001 << b));
            rdc(5'h11, 16'h0000);
        end
        ev = 8'h00;
        rdc(5'h11, 16'h0000);
        wr(5'h11, 16'hFF00);
        rdc(5'h11, 16'hFF00);
        // Interrupt pin polarity and masking.
        wr(5'h11, 16'h0100);
        wr(5'h10, 16'h4000);
        check("int_inact_hi", {15'h0000, irq}, 16'h0000);
        pulse(1);
        check("int_masked", {15'h0000, irq}, 16'h0000);
        pulse(0);
        check("int_act_hi", {15'h0000, irq}, 16'h0001);
        wr(5'h10, 16'h0000);
        check("int_act_lo", {15'h0000, irq}, 16'h0000);
        rdc(5'h11, 16'h0103);
        check("int_clr", {15'h0000, irq}, 16'h0001);
        // A frozen clock enable must drop an event that comes and goes meanwhile.
        ce = 1'b0;
        pulse(7);
        ce = 1'b1;
        rdc(5'h11, 16'h0100);
        jam = 1'b1;
        rdc(5'h10, 16'h2000);
        // Diagnostic results and the latched lock.
        {negotiated_duplex, spd, pass, lock} = 4'hF;
        @(posedge I_CLK);
        #1;
        lock = 1'b0;
        rdc(5'h12, 16'h0F22);
        rdc(5'h12, 16'h0E22);
        // Test register controls.
        wr(5'h13, 16'h0000);
        check("ratio_w", {14'h0000, ratio, comp}, 16'h0000);
        wr(5'h13, 16'hFFFF);
        rdc(5'h13, 16'hFFE0);
        results();
    end
endmodule : tb
